// file: logic/ioam_pkg.sv
// Package: register map, field positions and reset values of the own-address match block.
// Assumes a 32-bit APB slave with one aligned word per register.
package ioam_pkg;
    // ==========================================================
    // Register word indices and byte addresses
    localparam logic [11:0] OFS_SLOT0_IDX = 12'h01d4;
    localparam logic [11:0] OFS_SLOT1_IDX = 12'h01d6;
    localparam logic [11:0] OFS_SLOT2_IDX = 12'h01d8;
    localparam logic [13:0] ADDR_SLOT0 = {OFS_SLOT0_IDX, 2'b00};
    localparam logic [13:0] ADDR_SLOT1 = {OFS_SLOT1_IDX, 2'b00};
    localparam logic [13:0] ADDR_SLOT2 = {OFS_SLOT2_IDX, 2'b00};
    localparam logic [13:0] ADDR_CTRL = 14'h0800;
    localparam logic [13:0] ADDR_MASK = 14'h0804;
    localparam logic [13:0] ADDR_RXADDR = 14'h0808;
    localparam logic [13:0] ADDR_STATUS = 14'h080c;
    // ==========================================================
    // Field positions
    localparam int GCEN_BIT = 15;
    localparam int OAEN_BIT = 10;
    localparam int ADDR_MSB = 9;
    localparam int ADDR7_MSB = 6;
    localparam int CTRL_SWRST_BIT = 0;
    localparam int CTRL_MODE10_BIT = 1;
    localparam int STAT_GC_BIT = 0;
    localparam int STAT_MATCH_LSB = 1;
    // ==========================================================
    // Reset values, general call address and slot count
    localparam logic [15:0] SLOT_RESET = 16'h0000;
    localparam logic [9:0] MASK_RESET = 10'h03ff;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam logic [9:0] GC_ADDR = 10'h0000;
    localparam int NUM_SLOTS = 3;
endpackage

// file: logic/ioam_slot_cmp.sv
// Compare of one own-address slot against the bus address.
// Assumes slot fields are stable; purely combinational.
module ioam_slot_cmp (
    input wire logic [9:0] slot_address_value,
    input wire logic slot_address_en,
    input wire logic [9:0] address_compare_mask,
    input wire logic mode_10bit,
    input wire logic [9:0] bus_address,
    output logic hit
);
    logic [9:0] diff;
    always_comb begin
        diff = (slot_address_value ^ bus_address) & address_compare_mask;
        if (!mode_10bit) begin
            diff[ioam_pkg::ADDR_MSB:ioam_pkg::ADDR7_MSB+1] = 3'h0;
        end
        hit = slot_address_en && (diff == 10'h000);
    end
endmodule

// file: logic/ioam_top.sv
// Own-address slots, match logic and status for an I2C target, on APB.
// Assumes the serial engine supplies start, address-valid strobes and the address.
// What this block does
// - Slot 0 holds a general call answer enable at bit 15; other slots lack it.
// - Each slot's bit 10 enables that slot in address comparison.
// - The slot address sits right justified in bits 9..0.
// - In 7-bit mode bit 6 is the top bit and bits 9..7 are ignored.
// - In 10-bit mode all ten bits compare, bit 9 the top bit.
// - Slot fields change only while module soft reset is set.
// - All slots read zero after reset.
// - A cleared mask bit makes that address bit don't care; reset mask is all ones.
// - The last acknowledged target address is captured in a readable register.
// - General call reception sets a flag that a START clears.
module ioam_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bus_start,
    input wire logic bus_addr_valid,
    input wire logic [9:0] bus_address,
    output logic addr_ack,
    output logic module_soft_reset
);
    // ==========================================================
    // Registers
    logic [15:0] slot_reg [ioam_pkg::NUM_SLOTS];
    logic [9:0] address_compare_mask_reg;
    logic [1:0] ctrl_reg;
    logic [9:0] captured_target_address_reg;
    logic general_call_seen_flag_reg;
    logic [2:0] match_reg;
    logic addr_ack_reg;
    logic [2:0] hit;
    logic gc_hit;
    logic wr_en;
    logic rd_en;
    logic [13:0] a;
    logic mapped;
    logic [31:0] rdata_next;

    assign a = paddr[13:0];
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign module_soft_reset = ctrl_reg[ioam_pkg::CTRL_SWRST_BIT];
    assign pready = 1'b1;

    // ==========================================================
    // Address decode and read mux
    always_comb begin
        mapped = 1'b1;
        rdata_next = 32'h0000_0000;
        case (a)
            ioam_pkg::ADDR_SLOT0: rdata_next = {16'h0000, slot_reg[0]};
            ioam_pkg::ADDR_SLOT1: rdata_next = {16'h0000, slot_reg[1]};
            ioam_pkg::ADDR_SLOT2: rdata_next = {16'h0000, slot_reg[2]};
            ioam_pkg::ADDR_CTRL: rdata_next = {30'h0000_0000, ctrl_reg};
            ioam_pkg::ADDR_MASK: rdata_next = {22'h00_0000, address_compare_mask_reg};
            ioam_pkg::ADDR_RXADDR: begin
                rdata_next = {22'h00_0000, captured_target_address_reg};
            end
            ioam_pkg::ADDR_STATUS: rdata_next = {28'h000_0000, match_reg, general_call_seen_flag_reg};
            default: mapped = 1'b0;
        endcase
        if (paddr[31:14] != 18'h0_0000 || paddr[1:0] != 2'b00) begin
            mapped = 1'b0;
            rdata_next = 32'h0000_0000;
        end
    end
    assign pslverr = psel && penable && !mapped;

    // Read data loads in the setup phase so it stands through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= rdata_next;
        end
    end

    // ==========================================================
    // Slot registers, written only in soft reset
    genvar i;
    generate
        for (i = 0; i < ioam_pkg::NUM_SLOTS; i++) begin : g_slot
            localparam logic [13:0] SLOT_ADDR = (i == 0) ? ioam_pkg::ADDR_SLOT0 :
                (i == 1) ? ioam_pkg::ADDR_SLOT1 : ioam_pkg::ADDR_SLOT2;
            localparam logic [15:0] WMASK = (i == 0) ? 16'h87ff : 16'h07ff;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    slot_reg[i] <= ioam_pkg::SLOT_RESET;
                end else if (wr_en && mapped && a == SLOT_ADDR && module_soft_reset) begin
                    slot_reg[i] <= pwdata[15:0] & WMASK;
                end
            end
            ioam_slot_cmp u_cmp (
                .slot_address_value(slot_reg[i][ioam_pkg::ADDR_MSB:0]),
                .slot_address_en(slot_reg[i][ioam_pkg::OAEN_BIT]),
                .address_compare_mask(address_compare_mask_reg),
                .mode_10bit(ctrl_reg[ioam_pkg::CTRL_MODE10_BIT]),
                .bus_address(bus_address),
                .hit(hit[i])
            );
        end
    endgenerate

    // ==========================================================
    // Control and mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= ioam_pkg::CTRL_RESET;
        end else if (wr_en && mapped && a == ioam_pkg::ADDR_CTRL && pstrb[0]) begin
            ctrl_reg <= pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            address_compare_mask_reg <= ioam_pkg::MASK_RESET;
        end else if (wr_en && mapped && a == ioam_pkg::ADDR_MASK && module_soft_reset) begin
            address_compare_mask_reg <= pwdata[9:0];
        end
    end

    // ==========================================================
    // Match, capture and general call
    assign gc_hit = slot_reg[0][ioam_pkg::GCEN_BIT] && bus_address == ioam_pkg::GC_ADDR;
    assign addr_ack = addr_ack_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_ack_reg <= 1'b0;
            match_reg <= 3'h0;
        end else begin
            addr_ack_reg <= bus_addr_valid && !module_soft_reset && ((|hit) || gc_hit);
            if (bus_addr_valid && !module_soft_reset) begin
                match_reg <= hit;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            captured_target_address_reg <= 10'h000;
        end else if (bus_addr_valid && !module_soft_reset && ((|hit) || gc_hit)) begin
            captured_target_address_reg <= bus_address;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            general_call_seen_flag_reg <= 1'b0;
        end else if (bus_addr_valid && !module_soft_reset && gc_hit) begin
            general_call_seen_flag_reg <= 1'b1;
        end else if (bus_start || module_soft_reset) begin
            general_call_seen_flag_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    chk_slot_reset_zero: assert property (@(posedge pclk) $rose(presetn) |->
        slot_reg[0] == 16'h0000 && slot_reg[1] == 16'h0000 && slot_reg[2] == 16'h0000)
        else $error("slot not zero after reset");
    chk_write_locked: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(module_soft_reset) |-> $stable(slot_reg[1]))
        else $error("slot changed outside soft reset");
    chk_mask_locked: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(module_soft_reset) |-> $stable(address_compare_mask_reg))
        else $error("mask changed outside soft reset");
    chk_no_gcen_slot1: assert property (@(posedge pclk) disable iff (!presetn)
        slot_reg[1][15:11] == 5'h00 && slot_reg[2][15:11] == 5'h00)
        else $error("reserved slot bits set");
    chk_disabled_no_hit: assert property (@(posedge pclk) disable iff (!presetn)
        !slot_reg[0][ioam_pkg::OAEN_BIT] |-> !hit[0])
        else $error("disabled slot hit");
    chk_exact_hit: assert property (@(posedge pclk) disable iff (!presetn)
        slot_reg[1][ioam_pkg::OAEN_BIT] && address_compare_mask_reg == 10'h3ff &&
        ctrl_reg[1] && bus_address == slot_reg[1][9:0] |-> hit[1])
        else $error("10-bit exact match missed");
    chk_7bit_ignore: assert property (@(posedge pclk) disable iff (!presetn)
        slot_reg[1][ioam_pkg::OAEN_BIT] && !ctrl_reg[1] && address_compare_mask_reg == 10'h3ff &&
        bus_address[6:0] == slot_reg[1][6:0] |-> hit[1])
        else $error("7-bit match missed");
    chk_mask_dontcare: assert property (@(posedge pclk) disable iff (!presetn)
        slot_reg[0][ioam_pkg::OAEN_BIT] && ctrl_reg[1] &&
        ((bus_address ^ slot_reg[0][9:0]) & address_compare_mask_reg) == 10'h000 |-> hit[0])
        else $error("masked match missed");
    chk_ack_follows: assert property (@(posedge pclk) disable iff (!presetn)
        bus_addr_valid && !module_soft_reset && (|hit) |=>
        addr_ack && captured_target_address_reg == $past(bus_address))
        else $error("ack or capture missing");
    chk_ack_source: assert property (@(posedge pclk) disable iff (!presetn)
        addr_ack |-> $past(bus_addr_valid))
        else $error("ack without address strobe");
    chk_no_ack_in_reset: assert property (@(posedge pclk) disable iff (!presetn)
        module_soft_reset |=> !addr_ack)
        else $error("ack while in soft reset");
    chk_gc_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        bus_addr_valid && !module_soft_reset && !slot_reg[0][ioam_pkg::GCEN_BIT] && !(|hit)
        |=> !addr_ack)
        else $error("general call answered while disabled");
    chk_gc_flag: assert property (@(posedge pclk) disable iff (!presetn)
        bus_addr_valid && !module_soft_reset && gc_hit |=> general_call_seen_flag_reg)
        else $error("general call flag not set");
    chk_gc_start_clear: assert property (@(posedge pclk) disable iff (!presetn)
        bus_start && !(bus_addr_valid && !module_soft_reset && gc_hit) |=>
        !general_call_seen_flag_reg)
        else $error("general call flag not cleared by start");

    // ==========================================================
    // Covers
    cov_ack: cover property (@(posedge pclk) disable iff (!presetn) addr_ack);
    cov_gc: cover property (@(posedge pclk) disable iff (!presetn) $rose(general_call_seen_flag_reg));
    cov_multi: cover property (@(posedge pclk) disable iff (!presetn) hit == 3'h7);
    cov_masked_hit: cover property (@(posedge pclk) disable iff (!presetn)
        addr_ack && address_compare_mask_reg != 10'h3ff);
endmodule

// file: verification/ioam_bus_master_model.sv
// Bus master model: issues a START, then one address strobe to the target.
// Assumes the target samples strobes on the rising edge of pclk.
module ioam_bus_master_model (
    input wire logic pclk,
    output logic bus_start,
    output logic bus_addr_valid,
    output logic [9:0] bus_address
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Idle levels
    initial begin
        bus_start = 1'b0;
        bus_addr_valid = 1'b0;
        bus_address = 10'h03ff;
    end
    // ==========================================================
    // One addressing frame; the address line is inverted once released
    task automatic send(input logic [9:0] a);
        @(posedge pclk);
        bus_start <= 1'b1;
        @(posedge pclk);
        bus_start <= 1'b0;
        bus_addr_valid <= 1'b1;
        bus_address <= a;
        @(posedge pclk);
        bus_addr_valid <= 1'b0;
        bus_address <= ~a;
    endtask
endmodule

// file: verification/ioam_top_tb.sv
// Testbench: APB register accesses and address frames with expected values.
// Assumes a zero-wait APB slave and the bus master model beside it.
module ioam_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Signals
    localparam logic [31:0] A0 = {18'h0, ioam_pkg::ADDR_SLOT0};
    localparam logic [31:0] A1 = {18'h0, ioam_pkg::ADDR_SLOT1};
    localparam logic [31:0] A2 = {18'h0, ioam_pkg::ADDR_SLOT2};
    localparam logic [31:0] AC = {18'h0, ioam_pkg::ADDR_CTRL};
    localparam logic [31:0] AM = {18'h0, ioam_pkg::ADDR_MASK};
    localparam logic [31:0] AR = {18'h0, ioam_pkg::ADDR_RXADDR};
    localparam logic [31:0] AS = {18'h0, ioam_pkg::ADDR_STATUS};
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata, r;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, bus_start, bus_addr_valid, addr_ack, module_soft_reset, e;
    logic [9:0] bus_address;
    int fails = 0, checks = 0;
    always #20 pclk = ~pclk;
    ioam_top u_ioam_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus_start(bus_start),
        .bus_addr_valid(bus_addr_valid), .bus_address(bus_address), .addr_ack(addr_ack),
        .module_soft_reset(module_soft_reset));
    ioam_bus_master_model u_ioam_bus_master_model (.pclk(pclk), .bus_start(bus_start),
        .bus_addr_valid(bus_addr_valid), .bus_address(bus_address));
    // ==========================================================
    // Tasks
    task automatic results;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            fails++;
            results();
        end
        e = pslverr;
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(r, exp);
    endtask
    task automatic ack(input logic [9:0] a, input logic exp);
        u_ioam_bus_master_model.send(a);
        #1 chk({31'b0, addr_ack}, {31'b0, exp});
    endtask
    // ==========================================================
    // Sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1 chk({31'b0, module_soft_reset}, 32'h0000_0001);
        rd(A0, 32'h0000_0000);
        rd(A1, 32'h0000_0000);
        rd(A2, 32'h0000_0000);
        rd(AM, 32'h0000_03ff);
        apb(1'b1, A0, 32'hffff_ffff);
        rd(A0, 32'h0000_87ff);
        apb(1'b1, A1, 32'hffff_ffff);
        rd(A1, 32'h0000_07ff);
        apb(1'b1, A0, 32'h0000_8412);
        apb(1'b1, A1, 32'h0000_06a5);
        apb(1'b1, A2, 32'h0000_0055);
        apb(1'b1, AC, 32'h0000_0000);
        #1 chk({31'b0, module_soft_reset}, 32'h0000_0000);
        apb(1'b1, A0, 32'h0000_0000);
        rd(A0, 32'h0000_8412);
        ack(10'h012, 1'b1);
        ack(10'h025, 1'b1);
        ack(10'h055, 1'b0);
        ack(10'h000, 1'b1);
        rd(AS, 32'h0000_0001);
        rd(AR, 32'h0000_0000);
        ack(10'h012, 1'b1);
        rd(AS, 32'h0000_0002);
        rd(AR, 32'h0000_0012);
        apb(1'b1, AC, 32'h0000_0002);
        ack(10'h2a5, 1'b1);
        ack(10'h025, 1'b0);
        apb(1'b1, AC, 32'h0000_0003);
        apb(1'b1, AM, 32'h0000_03fe);
        apb(1'b1, A0, 32'h0000_0412);
        apb(1'b1, A2, 32'h0000_0455);
        ack(10'h012, 1'b0);
        apb(1'b1, AC, 32'h0000_0002);
        ack(10'h2a4, 1'b1);
        ack(10'h054, 1'b1);
        rd(AS, 32'h0000_0008);
        ack(10'h013, 1'b1);
        ack(10'h000, 1'b0);
        rd(32'h0000_0900, 32'h0000_0000);
        chk({31'b0, e}, 32'h0000_0001);
        results();
    end
endmodule
